// *** core/vector_compare_pkg.sv ***
package vector_compare_pkg;

  typedef enum logic [3:0] {
    PR_FALSE, PR_LT, PR_EQ, PR_LE, PR_GT, PR_NE, PR_GE, PR_TRUE,
    PR_NGT, PR_NLE, PR_NEQ, PR_NLT, PR_NONE
  } pred_t;

  typedef enum logic [2:0] {
    TY_NONE, TY_F64, TY_I16, TY_U16, TY_I32, TY_U32, TY_I64, TY_U64
  } opnd_t;

endpackage : vector_compare_pkg

// *** core/vector_compare_unit.sv ***
// Overview of operation
// (RQ1) Lane result lands in destination mask bit.
// (RQ2) Not-greater double is true on NaN.
// (RQ3) Not-less-equal double is true on NaN.
// (RQ4) Not-equal double inverts ordered equality.
// (RQ5) Not-less double is true on NaN.
// (RQ6) Constant-true variants set the lane bit.
// (RQ7) Constant-false variants clear the lane bit.
// (RQ8) Signed half gives less, equal, less-equal.
// (RQ9) Signed half gives greater, not-equal, greater-equal.
// (RQ10) Unsigned half gives all six predicates.
// (RQ11) Signed word gives all six predicates.
// (RQ12) Signed word greater decodes from 68.
// (RQ13) Unsigned word gives all six predicates.
// (RQ14) Signed doubleword gives all six predicates.
// (RQ15) Unsigned doubleword gives all six predicates.
// (RQ16) Unsigned doubleword false 88, greater-equal 94.
// (RQ17) Invalid on signalling NaN, quiet NaN if clamped.
// (RQ18) Lanes outside execution mask keep their bit.
`timescale 1ns/10ps
`include "vector_compare_unit_params.svh"

module vector_compare_unit (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Issue side.
  input wire logic in_valid,
  input wire logic [`VCU_OP_W-1:0] opcode,
  input wire logic clamp,
  input wire logic [`VCU_LANES-1:0] exec_mask,
  input wire logic [`VCU_LANES-1:0] mask_in,
  input wire logic [`VCU_LANES-1:0][`VCU_WIDTH-1:0] first_source,
  input wire logic [`VCU_LANES-1:0][`VCU_WIDTH-1:0] second_source,
  // Result side.
  output logic out_valid,
  output logic [`VCU_LANES-1:0] destination_mask,
  output logic invalid_op,
  output logic bad_opcode
);

  function automatic logic is_nan(input logic [`VCU_WIDTH-1:0] v);
    is_nan = (v[`VCU_EXP_HI:`VCU_EXP_LO] == `VCU_EXP_ONES) &&
             (v[`VCU_EXP_LO-1:0] != '0);
  endfunction : is_nan

  function automatic logic is_snan(input logic [`VCU_WIDTH-1:0] v);
    is_snan = is_nan(v) && !v[`VCU_QUIET_BIT];
  endfunction : is_snan

  // Integers are widened to 65 bits so one signed compare serves every group.
  function automatic logic signed [`VCU_WIDTH:0] widen(
    input vector_compare_pkg::opnd_t t,
    input logic [`VCU_WIDTH-1:0] v
  );
    case (t)
      vector_compare_pkg::TY_I16: widen = {{49{v[15]}}, v[15:0]}; // RQ8 RQ9
      vector_compare_pkg::TY_U16: widen = {49'h0, v[15:0]}; // RQ10
      vector_compare_pkg::TY_I32: widen = {{33{v[31]}}, v[31:0]}; // RQ11
      vector_compare_pkg::TY_U32: widen = {33'h0, v[31:0]}; // RQ13
      vector_compare_pkg::TY_I64: widen = {v[63], v}; // RQ14
      default: widen = {1'b0, v}; // RQ15
    endcase
  endfunction : widen

  function automatic logic lane_cmp(
    input vector_compare_pkg::pred_t p,
    input vector_compare_pkg::opnd_t t,
    input logic [`VCU_WIDTH-1:0] a,
    input logic [`VCU_WIDTH-1:0] b
  );
    logic un;
    logic lt;
    logic eq;
    logic gt;
    un = 1'b0;
    if (t == vector_compare_pkg::TY_F64) begin
      un = is_nan(a) || is_nan(b);
      // Plus and minus zero compare equal.
      eq = !un && ((a == b) ||
           (a[`VCU_EXP_HI:0] == '0 && b[`VCU_EXP_HI:0] == '0));
      if (a[`VCU_SIGN_BIT] != b[`VCU_SIGN_BIT]) begin
        lt = a[`VCU_SIGN_BIT];
      end else if (a[`VCU_SIGN_BIT]) begin
        lt = a[`VCU_EXP_HI:0] > b[`VCU_EXP_HI:0];
      end else begin
        lt = a[`VCU_EXP_HI:0] < b[`VCU_EXP_HI:0];
      end
      lt = lt && !un && !eq;
    end else begin
      lt = widen(t, a) < widen(t, b);
      eq = widen(t, a) == widen(t, b);
    end
    gt = !(lt || eq || un);
    case (p)
      vector_compare_pkg::PR_LT: lane_cmp = lt;
      vector_compare_pkg::PR_EQ: lane_cmp = eq;
      vector_compare_pkg::PR_LE: lane_cmp = lt || eq;
      vector_compare_pkg::PR_GT: lane_cmp = gt;
      vector_compare_pkg::PR_NE: lane_cmp = !eq;
      vector_compare_pkg::PR_GE: lane_cmp = gt || eq;
      vector_compare_pkg::PR_TRUE: lane_cmp = 1'b1; // RQ6
      vector_compare_pkg::PR_NGT: lane_cmp = !gt; // RQ2
      vector_compare_pkg::PR_NLE: lane_cmp = !(lt || eq); // RQ3
      vector_compare_pkg::PR_NEQ: lane_cmp = !eq; // RQ4
      vector_compare_pkg::PR_NLT: lane_cmp = !lt; // RQ5
      default: lane_cmp = 1'b0; // RQ7
    endcase
  endfunction : lane_cmp

  vector_compare_pkg::pred_t pred;
  vector_compare_pkg::opnd_t kind;
  logic [`VCU_OP_W-1:0] sub;
  logic [`VCU_LANES-1:0] lane_res;
  logic [`VCU_LANES-1:0] lane_inv;
  logic [`VCU_LANES-1:0] mask_next;
  logic [`VCU_LANES-1:0] mask_reg;
  logic valid_reg;
  logic invalid_reg;
  logic bad_reg;

  // Opcode decode.
  always_comb begin
    pred = vector_compare_pkg::PR_NONE;
    kind = vector_compare_pkg::TY_NONE;
    sub = opcode - `VCU_BASE_F64;
    if (opcode >= `VCU_BASE_F64 && opcode < `VCU_BASE_I16) begin
      kind = vector_compare_pkg::TY_F64;
      case (sub)
        `VCU_FSUB_F: pred = vector_compare_pkg::PR_FALSE;
        `VCU_FSUB_NGT: pred = vector_compare_pkg::PR_NGT;
        `VCU_FSUB_NLE: pred = vector_compare_pkg::PR_NLE;
        `VCU_FSUB_NEQ: pred = vector_compare_pkg::PR_NEQ;
        `VCU_FSUB_NLT: pred = vector_compare_pkg::PR_NLT;
        `VCU_FSUB_T: pred = vector_compare_pkg::PR_TRUE;
        default: kind = vector_compare_pkg::TY_NONE;
      endcase
    end else if (opcode >= `VCU_INT_FIRST && opcode <= `VCU_INT_LAST) begin
      // Integer groups are eight opcodes each, predicate in the low bits.
      sub = opcode & `VCU_SUB_T;
      pred = vector_compare_pkg::pred_t'({1'b0, sub[2:0]}); // RQ12 RQ16
      case (opcode - sub)
        `VCU_BASE_I16: kind = vector_compare_pkg::TY_I16;
        `VCU_BASE_U16: kind = vector_compare_pkg::TY_U16;
        `VCU_BASE_I32: kind = vector_compare_pkg::TY_I32;
        `VCU_BASE_U32: kind = vector_compare_pkg::TY_U32;
        `VCU_BASE_I64: kind = vector_compare_pkg::TY_I64;
        default: kind = vector_compare_pkg::TY_U64;
      endcase
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `VCU_LANES; gi = gi + 1) begin : g_lane
      assign lane_res[gi] = lane_cmp(pred, kind, first_source[gi], second_source[gi]);
      // Integer operands carry no NaN, so only the double group can trap.
      assign lane_inv[gi] = exec_mask[gi] && kind == vector_compare_pkg::TY_F64 &&
        (is_snan(first_source[gi]) || is_snan(second_source[gi]) ||
         (clamp && (is_nan(first_source[gi]) || is_nan(second_source[gi])))); // RQ17
      // An unknown opcode leaves every lane untouched rather than writing junk.
      assign mask_next[gi] = (exec_mask[gi] && kind != vector_compare_pkg::TY_NONE) ?
        lane_res[gi] : mask_in[gi]; // RQ1 RQ18
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (srst) begin
      mask_reg <= `VCU_MASK_RST;
    end else if (in_valid) begin
      mask_reg <= mask_next; // RQ1
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      valid_reg <= 1'b0;
      invalid_reg <= 1'b0;
      bad_reg <= 1'b0;
    end else begin
      valid_reg <= in_valid;
      invalid_reg <= in_valid && (|lane_inv); // RQ17
      bad_reg <= in_valid && kind == vector_compare_pkg::TY_NONE;
    end
  end

  assign out_valid = valid_reg;
  assign destination_mask = mask_reg;
  assign invalid_op = invalid_reg;
  assign bad_opcode = bad_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence f64_lane0_nan_s(logic [`VCU_OP_W-1:0] sub_op);
    in_valid && opcode == `VCU_BASE_F64 + sub_op && exec_mask[0] &&
    is_nan(first_source[0]);
  endsequence

  sequence int_lane0_s(logic [`VCU_OP_W-1:0] op);
    in_valid && opcode == op && exec_mask[0];
  endsequence

  gt_word_decode_a: assert property ( // RQ12
    opcode == 8'h44 |-> pred == vector_compare_pkg::PR_GT &&
    kind == vector_compare_pkg::TY_I32)
    else $error("opcode 68 not decoded as signed word greater");

  u64_decode_a: assert property ( // RQ16
    (opcode == 8'h58 |-> pred == vector_compare_pkg::PR_FALSE &&
     kind == vector_compare_pkg::TY_U64) and
    (opcode == 8'h5e |-> pred == vector_compare_pkg::PR_GE &&
     kind == vector_compare_pkg::TY_U64))
    else $error("unsigned doubleword decode wrong");

  ngt_nan_a: assert property ( // RQ2
    f64_lane0_nan_s(`VCU_FSUB_NGT) |=> destination_mask[0])
    else $error("not-greater double false on NaN");

  nle_nan_a: assert property ( // RQ3
    f64_lane0_nan_s(`VCU_FSUB_NLE) |=> destination_mask[0])
    else $error("not-less-equal double false on NaN");

  neq_nan_a: assert property ( // RQ4
    f64_lane0_nan_s(`VCU_FSUB_NEQ) |=> destination_mask[0])
    else $error("not-equal double false on NaN");

  nlt_nan_a: assert property ( // RQ5
    f64_lane0_nan_s(`VCU_FSUB_NLT) |=> destination_mask[0])
    else $error("not-less double false on NaN");

  true_fill_a: assert property ( // RQ6
    in_valid && opcode == `VCU_BASE_U32 + `VCU_SUB_T |=>
    destination_mask == ($past(mask_in) | $past(exec_mask)))
    else $error("constant true did not set active lanes");

  false_clear_a: assert property ( // RQ7
    in_valid && opcode == `VCU_BASE_U64 + `VCU_SUB_F |=>
    destination_mask == ($past(mask_in) & ~$past(exec_mask)))
    else $error("constant false did not clear active lanes");

  half_signed_lt_a: assert property ( // RQ8
    int_lane0_s(`VCU_BASE_I16 + `VCU_SUB_LT) |=> destination_mask[0] ==
    ($signed($past(first_source[0][15:0])) < $signed($past(second_source[0][15:0]))))
    else $error("signed half less wrong");

  half_signed_ne_a: assert property ( // RQ9
    int_lane0_s(`VCU_BASE_I16 + `VCU_SUB_NE) |=> destination_mask[0] ==
    ($past(first_source[0][15:0]) != $past(second_source[0][15:0])))
    else $error("signed half not-equal wrong");

  half_unsigned_gt_a: assert property ( // RQ10
    int_lane0_s(`VCU_BASE_U16 + `VCU_SUB_GT) |=> destination_mask[0] ==
    ($past(first_source[0][15:0]) > $past(second_source[0][15:0])))
    else $error("unsigned half greater wrong");

  word_signed_ge_a: assert property ( // RQ11
    int_lane0_s(`VCU_BASE_I32 + `VCU_SUB_GE) |=> destination_mask[0] ==
    ($signed($past(first_source[0][31:0])) >= $signed($past(second_source[0][31:0]))))
    else $error("signed word greater-equal wrong");

  word_unsigned_le_a: assert property ( // RQ13
    int_lane0_s(`VCU_BASE_U32 + `VCU_SUB_LE) |=> destination_mask[0] ==
    ($past(first_source[0][31:0]) <= $past(second_source[0][31:0])))
    else $error("unsigned word less-equal wrong");

  dword_signed_lt_a: assert property ( // RQ14
    int_lane0_s(`VCU_BASE_I64 + `VCU_SUB_LT) |=> destination_mask[0] ==
    ($signed($past(first_source[0])) < $signed($past(second_source[0]))))
    else $error("signed doubleword less wrong");

  dword_unsigned_ge_a: assert property ( // RQ15
    int_lane0_s(`VCU_BASE_U64 + `VCU_SUB_GE) |=> destination_mask[0] ==
    ($past(first_source[0]) >= $past(second_source[0])))
    else $error("unsigned doubleword greater-equal wrong");

  snan_flag_a: assert property ( // RQ17
    in_valid && opcode == `VCU_BASE_F64 + `VCU_FSUB_T && exec_mask[0] &&
    (is_snan(first_source[0]) || is_snan(second_source[0])) |=> invalid_op && out_valid)
    else $error("signalling NaN did not raise invalid");

  inactive_hold_a: assert property ( // RQ18
    in_valid |=> (destination_mask & ~$past(exec_mask)) ==
    ($past(mask_in) & ~$past(exec_mask)))
    else $error("inactive lane bit changed");

  result_timing_a: assert property ( // RQ1
    in_valid |=> out_valid ##1 (out_valid == $past(in_valid)))
    else $error("result valid not one cycle after issue");

  // Reset must clear the outputs even though every other check is disabled by it.
  reset_clear_a: assert property (
    disable iff (1'b0) srst |=> !out_valid && !invalid_op && !bad_opcode &&
    destination_mask == `VCU_MASK_RST)
    else $error("outputs not cleared by reset");

  idle_quiet_a: assert property (
    !in_valid |=> !out_valid && !invalid_op && !bad_opcode && $stable(destination_mask))
    else $error("outputs moved without an issue");

  bad_opcode_keep_a: assert property (
    in_valid && kind == vector_compare_pkg::TY_NONE |=>
    bad_opcode && destination_mask == $past(mask_in))
    else $error("unknown opcode changed the mask");

  int_no_trap_a: assert property ( // RQ17
    in_valid && opcode >= `VCU_INT_FIRST && opcode <= `VCU_INT_LAST |=> !invalid_op)
    else $error("integer compare raised invalid");

  qnan_clamp_a: assert property ( // RQ17
    in_valid && kind == vector_compare_pkg::TY_F64 && clamp && exec_mask[0] &&
    is_nan(first_source[0]) |=> invalid_op)
    else $error("clamped quiet NaN did not raise invalid");

  word_signed_gt_a: assert property ( // RQ12
    int_lane0_s(`VCU_BASE_I32 + `VCU_SUB_GT) |=> destination_mask[0] ==
    ($signed($past(first_source[0][31:0])) > $signed($past(second_source[0][31:0]))))
    else $error("signed word greater wrong");

  half_signed_le_a: assert property ( // RQ8
    int_lane0_s(`VCU_BASE_I16 + `VCU_SUB_LE) |=> destination_mask[0] ==
    ($signed($past(first_source[0][15:0])) <= $signed($past(second_source[0][15:0]))))
    else $error("signed half less-equal wrong");

  half_unsigned_ne_a: assert property ( // RQ10
    int_lane0_s(`VCU_BASE_U16 + `VCU_SUB_NE) |=> destination_mask[0] ==
    ($past(first_source[0][15:0]) != $past(second_source[0][15:0])))
    else $error("unsigned half not-equal wrong");

  word_unsigned_eq_a: assert property ( // RQ13
    int_lane0_s(`VCU_BASE_U32 + `VCU_SUB_EQ) |=> destination_mask[0] ==
    ($past(first_source[0][31:0]) == $past(second_source[0][31:0])))
    else $error("unsigned word equal wrong");

  dword_signed_ne_a: assert property ( // RQ14
    int_lane0_s(`VCU_BASE_I64 + `VCU_SUB_NE) |=> destination_mask[0] ==
    ($past(first_source[0]) != $past(second_source[0])))
    else $error("signed doubleword not-equal wrong");

  dword_unsigned_lt_a: assert property ( // RQ15
    int_lane0_s(`VCU_BASE_U64 + `VCU_SUB_LT) |=> destination_mask[0] ==
    ($past(first_source[0]) < $past(second_source[0])))
    else $error("unsigned doubleword less wrong");

endmodule : vector_compare_unit

// *** core/vector_compare_unit_params.svh ***
`ifndef VECTOR_COMPARE_UNIT_PARAMS_SVH
`define VECTOR_COMPARE_UNIT_PARAMS_SVH

// Wave width and operand width.
`define VCU_LANES 64
`define VCU_WIDTH 64
`define VCU_OP_W 8

// Compare opcode group bases.
`define VCU_BASE_F64 8'h20
`define VCU_BASE_I16 8'h30
`define VCU_BASE_U16 8'h38
`define VCU_BASE_I32 8'h40
`define VCU_BASE_U32 8'h48
`define VCU_BASE_I64 8'h50
`define VCU_BASE_U64 8'h58
`define VCU_INT_FIRST 8'h30
`define VCU_INT_LAST 8'h5f

// Predicate offsets inside an integer group.
`define VCU_SUB_F 8'h00
`define VCU_SUB_LT 8'h01
`define VCU_SUB_EQ 8'h02
`define VCU_SUB_LE 8'h03
`define VCU_SUB_GT 8'h04
`define VCU_SUB_NE 8'h05
`define VCU_SUB_GE 8'h06
`define VCU_SUB_T 8'h07

// Predicate offsets inside the double-precision group.
`define VCU_FSUB_F 8'h00
`define VCU_FSUB_NGT 8'h0b
`define VCU_FSUB_NLE 8'h0c
`define VCU_FSUB_NEQ 8'h0d
`define VCU_FSUB_NLT 8'h0e
`define VCU_FSUB_T 8'h0f

// Double-precision field positions.
`define VCU_SIGN_BIT 63
`define VCU_EXP_HI 62
`define VCU_EXP_LO 52
`define VCU_QUIET_BIT 51
`define VCU_EXP_ONES 11'h7ff

// Reset values.
`define VCU_MASK_RST 64'h0

`endif

// *** tb/issue_model.sv ***
`timescale 1ns/10ps
`include "vector_compare_unit_params.svh"

module issue_model (
  // Clock.
  input wire logic clk,
  // Issue side toward the compare unit.
  output logic in_valid,
  output logic [`VCU_OP_W-1:0] opcode,
  output logic clamp,
  output logic [`VCU_LANES-1:0] exec_mask,
  output logic [`VCU_LANES-1:0] mask_in,
  output logic [`VCU_LANES-1:0][`VCU_WIDTH-1:0] first_source,
  output logic [`VCU_LANES-1:0][`VCU_WIDTH-1:0] second_source
);
  initial begin
    in_valid = 1'b0;
    opcode = 8'h00;
    clamp = 1'b0;
    exec_mask = 64'h0;
    mask_in = 64'h0;
    first_source = '0;
    second_source = '0;
  end

  // Odd lanes get the operands swapped so that neighbouring lanes disagree.
  task automatic send(input logic [7:0] op, input logic cl, input logic [63:0] em,
                      input logic [63:0] mi, input logic [63:0] a, input logic [63:0] b);
    @(posedge clk);
    #1;
    in_valid = 1'b1;
    opcode = op;
    clamp = cl;
    exec_mask = em;
    mask_in = mi;
    for (int i = 0; i < `VCU_LANES; i++) begin
      first_source[i] = i[0] ? b : a;
      second_source[i] = i[0] ? a : b;
    end
    @(posedge clk);
    #1;
    // Released opcode, mask_in and operands are scrambled, so a late sample cannot pass by luck.
    in_valid = 1'b0;
    opcode = ~opcode;
    mask_in = ~mask_in;
    first_source = ~first_source;
    second_source = ~second_source;
  endtask : send
endmodule : issue_model

// *** tb/vector_compare_unit_tb_top.sv ***
`timescale 1ns/10ps

module vector_compare_unit_tb_top;
  logic clk, srst, in_valid, clamp, out_valid, invalid_op, bad_opcode;
  logic [7:0] opcode;
  logic [63:0] exec_mask, mask_in, destination_mask;
  logic [63:0][63:0] first_source, second_source;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [63:0] pa [5] = '{64'hffff_ffff_ffff_8000, 64'h1234_5678_9abc_def0,
    64'h0001_0000_0000_0005, 64'h7ff8_0000_0000_0000, 64'h7ff0_0000_0000_0001};
  logic [63:0] pb [5] = '{64'h1, 64'h1234_5678_9abc_def0, 64'h5, 64'h3ff0_0000_0000_0000,
    64'h4000_0000_0000_0000};
  logic [63:0] fa [3] = '{64'h3ff0_0000_0000_0000, 64'h3ff0_0000_0000_0000,
    64'h8000_0000_0000_0000};
  logic [63:0] fb [3] = '{64'h4000_0000_0000_0000, 64'h3ff0_0000_0000_0000, 64'h0};
  logic [7:0] fops [6] = '{8'h20, 8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f};

  vector_compare_unit i_vector_compare_unit (.clk(clk), .srst(srst), .in_valid(in_valid),
    .opcode(opcode), .clamp(clamp), .exec_mask(exec_mask), .mask_in(mask_in),
    .first_source(first_source), .second_source(second_source), .out_valid(out_valid),
    .destination_mask(destination_mask), .invalid_op(invalid_op), .bad_opcode(bad_opcode));
  issue_model i_issue_model (.clk(clk), .in_valid(in_valid), .opcode(opcode), .clamp(clamp),
    .exec_mask(exec_mask), .mask_in(mask_in), .first_source(first_source),
    .second_source(second_source));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic is_nan(logic [63:0] v, logic any);
    return v[62:52] == 11'h7ff && v[51:0] != 52'h0 && (any || !v[51]);
  endfunction : is_nan

  // Signed order is mapped onto unsigned order by flipping the sign bit.
  function automatic logic pred(logic [7:0] op, logic [63:0] a, logic [63:0] b);
    logic [63:0] x, y;
    int w;
    logic lt, eq, gt;
    if (op < 8'h30) begin
      lt = 1'b0;
      eq = 1'b0;
      gt = 1'b0;
      if (!is_nan(a, 1'b1) && !is_nan(b, 1'b1)) begin
        lt = $bitstoreal(a) < $bitstoreal(b);
        eq = $bitstoreal(a) == $bitstoreal(b);
        gt = $bitstoreal(a) > $bitstoreal(b);
      end
      case (op[3:0])
        4'hb: return !gt;
        4'hc: return !(lt || eq);
        4'hd: return !eq;
        4'he: return !lt;
        4'hf: return 1'b1;
        default: return 1'b0;
      endcase
    end
    w = (op < 8'h40) ? 16 : (op < 8'h50) ? 32 : 64;
    x = (w == 64) ? a : a & ((64'h1 << w) - 64'h1);
    y = (w == 64) ? b : b & ((64'h1 << w) - 64'h1);
    if (!op[3]) begin
      x[w-1] = ~x[w-1];
      y[w-1] = ~y[w-1];
    end
    lt = x < y;
    eq = x == y;
    case (op[2:0])
      3'h0: return 1'b0;
      3'h1: return lt;
      3'h2: return eq;
      3'h3: return lt || eq;
      3'h4: return !(lt || eq);
      3'h5: return !eq;
      3'h6: return !lt;
      default: return 1'b1;
    endcase
  endfunction : pred

  function automatic logic [63:0] emask(logic [7:0] op, logic [63:0] a, logic [63:0] b);
    return {32{pred(op, b, a), pred(op, a, b)}};
  endfunction : emask

  task automatic run(input logic [7:0] op, input logic cl, input logic [63:0] em,
                     input logic [63:0] mi, input logic [63:0] a, input logic [63:0] b);
    i_issue_model.send(op, cl, em, mi, a, b);
    chk(64'(out_valid), 64'h1);
  endtask : run

  task automatic t_reset();
    chk({out_valid, invalid_op, bad_opcode}, 64'h0);
    chk(destination_mask, 64'h0);
  endtask : t_reset

  task automatic t_int();
    logic [63:0] exp;
    for (int op = 8'h30; op <= 8'h5f; op++) begin
      for (int p = 0; p < 5; p++) begin
        run(8'(op), 1'b1, '1, 64'h0, pa[p], pb[p]);
        exp = emask(8'(op), pa[p], pb[p]);
        chk(destination_mask, exp);
        chk({invalid_op, bad_opcode}, 64'h0);
      end
    end
  endtask : t_int

  task automatic t_f64();
    logic [63:0] a, b;
    for (int k = 0; k < 12; k++) begin
      for (int o = 0; o < 6; o++) begin
        // Slots 3 to 5 reuse the last three integer pairs, two of which hold a NaN.
        a = (k % 6 < 3) ? fa[k % 6] : pa[k % 6 - 1];
        b = (k % 6 < 3) ? fb[k % 6] : pb[k % 6 - 1];
        run(fops[o], k >= 6, '1, 64'h0, a, b);
        chk(destination_mask, emask(fops[o], a, b));
        chk(64'(invalid_op), 64'(is_nan(a, k >= 6) || is_nan(b, k >= 6)));
      end
    end
  endtask : t_f64

  task automatic t_mask();
    logic [63:0] em, mi, exp;
    em = 64'h0f0f_00ff_f0f0_1234;
    mi = 64'ha5a5_5a5a_c3c3_3c3c;
    exp = (emask(8'h44, pa[0], pb[0]) & em) | (mi & ~em);
    run(8'h44, 1'b0, em, mi, pa[0], pb[0]);
    chk(destination_mask, exp);
    run(8'h21, 1'b0, em, mi, pa[0], pb[0]);
    chk(64'(bad_opcode), 64'h1);
    chk(destination_mask, mi);
    @(posedge clk);
    #1;
    chk(64'(out_valid), 64'h0);
    chk(destination_mask, mi);
  endtask : t_mask

  task automatic t_midreset();
    run(8'h4f, 1'b0, '1, 64'h0, pa[0], pb[0]);
    chk(destination_mask, '1);
    srst = 1'b1;
    @(posedge clk);
    #1;
    srst = 1'b0;
    t_reset();
  endtask : t_midreset

  initial begin
    srst = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    srst = 1'b0;
    t_reset();
    t_int();
    t_f64();
    t_mask();
    t_midreset();
    end_sim();
  end
endmodule : vector_compare_unit_tb_top
